/* File: rtl/ppsup_pkg.sv */
// Package for the port power supervisor: thresholds, timing, states.
// Assumes a 100 MHz clock; currents are in mA, voltages in units of 0.1 V.
package ppsup_pkg;
   localparam int CLK_MHZ = 100;
   // Current thresholds, mA
   localparam logic [11:0] STARTUP_LIMIT_MA = 12'h1A4;  // 420
   localparam logic [11:0] C5A_CUT_MA = 12'h2EC;        // 748
   localparam logic [11:0] C5A_LIM_MA = 12'h352;        // 850
   localparam logic [11:0] C5B_CUT_MA = 12'h318;        // 792
   localparam logic [11:0] C5B_LIM_MA = 12'h384;        // 900
   localparam logic [11:0] C5C_CUT_MA = 12'h344;        // 836
   localparam logic [11:0] C5C_LIM_MA = 12'h3B6;        // 950
   // Cut threshold ratio, 88 percent as 225/256
   localparam logic [7:0] CUT_RATIO_Q8 = 8'hE1;
   // Foldback knees and overvoltage level, 0.1 V units
   localparam logic [9:0] FOLD_HI_DV = 10'h10E;  // 27.0 V
   localparam logic [9:0] FOLD_LO_DV = 10'h064;  // 10.0 V
   localparam logic [9:0] OV_DV = 10'h271;       // 62.5 V
   // Undervoltage qualification, 2.5 ms
   localparam int UVLO_US = 2500;
   localparam int UVLO_CYC = UVLO_US * CLK_MHZ + 1;
   // Dimming wave: 25 kHz, 1/16 high
   localparam int DIM_PERIOD_CYC = (CLK_MHZ * 1000) / 25;
   localparam int DIM_HIGH_CYC = DIM_PERIOD_CYC / 16;
   // Fault counter steps
   localparam logic [3:0] FAULT_UP_STEP = 4'h8;
   localparam logic [3:0] FAULT_DOWN_STEP = 4'h1;
   // LED code lengths
   localparam logic [2:0] FLASH_OC = 3'h2;
   localparam logic [2:0] FLASH_SIG = 3'h5;
   typedef enum {ST_OFF, ST_STARTUP, ST_NORMAL, ST_COOLDOWN} ppsup_state_t;
   typedef enum {LED_DARK, LED_SOLID, LED_CODE2, LED_CODE5} ppsup_led_t;
endpackage

/* File: rtl/ppsup_if.sv */
// Interface between the supervisor and its LED code generator.
// Assumes both ends share the supervisor clock.
`timescale 1ns/1ps
interface ppsup_led_if;
   ppsup_pkg::ppsup_led_t mode;
   logic dim_en;
   logic led_on;
   modport ctrl (output mode, output dim_en, input led_on);
   modport gen (input mode, input dim_en, output led_on);
endinterface

/* File: rtl/ppsup_led_gen.sv */
// LED pattern generator: steady, flash codes and dimming wave.
// Assumes a 100 MHz clock; flash timing parameters are counts of cycles.
`timescale 1ns/1ps
module ppsup_led_gen
   import ppsup_pkg::*;
#(
   parameter int FLASH_CYC = 25000000,
   parameter int GAP_CYC = 100000000
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pattern control
   ppsup_led_if.gen led
);
   localparam int TW = $clog2(GAP_CYC + 1);
   logic [12:0] dim_cnt_ff;
   logic [TW-1:0] tick_ff;
   logic [3:0] phase_ff;
   logic dim_wave;
   logic [2:0] flashes;
   logic flash_on;

   // Dimming square wave
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         dim_cnt_ff <= 13'h0000;
      else if (dim_cnt_ff == 13'(DIM_PERIOD_CYC - 1))
         dim_cnt_ff <= 13'h0000;
      else
         dim_cnt_ff <= dim_cnt_ff + 13'h0001;
   end
   // [RULE20] Dimming wave shape
   assign dim_wave = (dim_cnt_ff < 13'(DIM_HIGH_CYC));

   // Flash phase sequencer: on/off halves, then a long gap
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tick_ff <= '0;
         phase_ff <= 4'h0;
      end
      else if (led.mode != LED_CODE2 && led.mode != LED_CODE5)
      begin
         tick_ff <= '0;
         phase_ff <= 4'h0;
      end
      else if ((phase_ff == {flashes, 1'b0} && tick_ff == TW'(GAP_CYC - 1)) ||
               (phase_ff != {flashes, 1'b0} && tick_ff == TW'(FLASH_CYC - 1)))
      begin
         tick_ff <= '0;
         phase_ff <= (phase_ff == {flashes, 1'b0}) ? 4'h0 : phase_ff + 4'h1;
      end
      else
         tick_ff <= tick_ff + 1'b1;
   end

   // [RULE18] [RULE19] Flash count per code
   assign flashes = (led.mode == LED_CODE2) ? FLASH_OC : FLASH_SIG;
   assign flash_on = !phase_ff[0] && (phase_ff < {flashes, 1'b0});

   // [RULE21] Dimming gate on lit periods
   always_comb
   begin
      case (led.mode)
         LED_SOLID: led.led_on = led.dim_en ? dim_wave : 1'b1;
         LED_CODE2, LED_CODE5: led.led_on = flash_on && (led.dim_en ? dim_wave : 1'b1);
         default: led.led_on = 1'b0;
      endcase
   end
endmodule // ppsup_led_gen

/* File: rtl/ppsup_top.sv */
// Port power supervisor: power states, fault counter, lockouts, LED.
// Assumes analog front end supplies measured current/voltage as sampled words.
//
// Behaviour
// [RULE1] Entering powered state clears fault and disconnect timers.
// [RULE2] Stay in startup until startup timer ends, then normal power.
// [RULE3] Two limit selects pick class 5 cut/limit pairs or disable it.
// [RULE4] Normal state flags overcurrent above about 88 percent of limit.
// [RULE5] Counter rises above limit in startup, above cut when normal.
// [RULE6] Below threshold the counter falls slower than it rises.
// [RULE7] Counter at full scale removes power; continuous fault takes one period.
// [RULE8] After fault power-off counter decays; no re-power until zero.
// [RULE9] Normal thresholds come from class; startup always uses 420 mA.
// [RULE10] Limit and cut fold back below 27 V, floor below 10 V.
// [RULE11] Port off and in reset until supply above UV for over 2.5 ms.
// [RULE12] Supply overvoltage turns the port off.
// [RULE13] Disconnect pin low at reset selects DC disconnect.
// [RULE14] DC mode: current below DC threshold too long removes power.
// [RULE15] Board fits a capacitor on mode pin to choose AC disconnect.
// [RULE16] AC mode: probe peak below AC threshold too long removes power.
// [RULE17] LED steady when powered, off when unpowered.
// [RULE18] Overcurrent at power-on gives repeated two-flash code.
// [RULE19] Bad signature resistance gives repeated five-flash code.
// [RULE20] Dimming wave near 25 kHz, 6.25 percent high.
// [RULE21] Dimming enable gates LED through wave; low drives directly.
// [RULE22] Over-temperature shuts down; below 130 C device resets.
// [RULE23] Mode selections captured only during reset.
// [RULE24] Enable low resets device; release when enable high.
// [RULE25] Counter saturates, up step several times down step.
`timescale 1ns/1ps
module ppsup_top
   import ppsup_pkg::*;
#(
   parameter int STARTUP_CYC = 6000000,
   parameter int FAULT_SCALE = 6000000,
   parameter int DISC_CYC = 30000000,
   parameter int UVLO_QUAL_CYC = UVLO_CYC,
   parameter int LED_FLASH_CYC = 25000000,
   parameter int LED_GAP_CYC = 100000000
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pins and comparators from the analog side
   input wire logic i_enable,
   input wire logic i_limit_select_a_n,
   input wire logic i_limit_select_b_n,
   input wire logic i_disconnect_mode_pin,
   input wire logic i_cadence_mode,
   input wire logic i_high_cap,
   input wire logic i_led_dimming_enable,
   input wire logic i_supply_undervoltage_lockout_n,
   input wire logic i_supply_overvoltage_detect,
   input wire logic i_over_temp,
   input wire logic i_under_temp_130,
   // From detection/classification
   input wire logic i_load_valid,
   input wire logic i_sig_bad,
   input wire logic [2:0] i_class,
   input wire logic [11:0] i_class_limit_ma,
   // Measurements
   input wire logic [11:0] i_sensed_load_current,
   input wire logic [11:0] i_dc_disconnect_threshold,
   input wire logic [11:0] i_probe_peak,
   input wire logic [11:0] i_ac_disconnect_threshold,
   input wire logic [11:0] i_foldback_current_floor,
   input wire logic [9:0] i_port_dv,
   input wire logic [9:0] i_supply_dv,
   // Outputs
   output logic o_port_on,
   output logic [11:0] o_current_limit_threshold,
   output logic o_overcurrent,
   output logic o_in_reset,
   output logic o_cadence_mode,
   output logic o_high_cap,
   output logic o_led_out,
   output logic o_led_oe
);
   localparam int FW = $clog2(FAULT_SCALE + 16);
   localparam int SW = $clog2(STARTUP_CYC + 1);
   localparam int DW = $clog2(DISC_CYC + 1);
   localparam int UW = $clog2(UVLO_QUAL_CYC + 1);

   ppsup_state_t state_ff;
   logic [2:0] en_sync_ff, uv_sync_ff, ov_sync_ff, ot_sync_ff, ut_sync_ff, dm_sync_ff;
   logic [2:0] dim_sync_ff, lsa_sync_ff, lsb_sync_ff;
   logic en_q, uv_ok_q, ov_q, ot_q, cool_q, dm_q, dim_q, lsa_q, lsb_q;
   logic [UW-1:0] uv_cnt_ff;
   logic uv_ok_ff, thermal_ff, run_ff, run_d_ff;
   logic ac_mode_ff, cad_ff, hcap_ff, c5a_ff, c5b_ff;
   logic [FW-1:0] fault_ff;
   logic [SW-1:0] start_cnt_ff;
   logic [DW-1:0] disc_cnt_ff;
   logic oc_fault_ff;
   logic [11:0] lim_base, lim_fold, cut;
   logic [19:0] cut_prod;
   logic [21:0] fold_prod;
   logic over_lim, over_cut, over_now, disc_low, fault_full, soft_rst;
   ppsup_led_if led_bus ();

   // Pin synchronisers: change accepted when stages two and three agree
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         en_sync_ff <= 3'h0;
         uv_sync_ff <= 3'h0;
         ov_sync_ff <= 3'h0;
         ot_sync_ff <= 3'h0;
         ut_sync_ff <= 3'h0;
         dm_sync_ff <= 3'h0;
         dim_sync_ff <= 3'h7;
         lsa_sync_ff <= 3'h7;
         lsb_sync_ff <= 3'h7;
         en_q <= 1'b0;
         uv_ok_q <= 1'b0;
         ov_q <= 1'b0;
         ot_q <= 1'b0;
         cool_q <= 1'b0;
         dm_q <= 1'b0;
         dim_q <= 1'b1;
         lsa_q <= 1'b1;
         lsb_q <= 1'b1;
      end
      else
      begin
         en_sync_ff <= {en_sync_ff[1:0], i_enable};
         uv_sync_ff <= {uv_sync_ff[1:0], i_supply_undervoltage_lockout_n};
         ov_sync_ff <= {ov_sync_ff[1:0], i_supply_overvoltage_detect};
         ot_sync_ff <= {ot_sync_ff[1:0], i_over_temp};
         ut_sync_ff <= {ut_sync_ff[1:0], i_under_temp_130};
         dm_sync_ff <= {dm_sync_ff[1:0], i_disconnect_mode_pin};
         dim_sync_ff <= {dim_sync_ff[1:0], i_led_dimming_enable};
         lsa_sync_ff <= {lsa_sync_ff[1:0], i_limit_select_a_n};
         lsb_sync_ff <= {lsb_sync_ff[1:0], i_limit_select_b_n};
         if (en_sync_ff[1] == en_sync_ff[2]) en_q <= en_sync_ff[2];
         if (uv_sync_ff[1] == uv_sync_ff[2]) uv_ok_q <= uv_sync_ff[2];
         if (ov_sync_ff[1] == ov_sync_ff[2]) ov_q <= ov_sync_ff[2];
         if (ot_sync_ff[1] == ot_sync_ff[2]) ot_q <= ot_sync_ff[2];
         if (ut_sync_ff[1] == ut_sync_ff[2]) cool_q <= ut_sync_ff[2];
         if (dm_sync_ff[1] == dm_sync_ff[2]) dm_q <= dm_sync_ff[2];
         if (dim_sync_ff[1] == dim_sync_ff[2]) dim_q <= dim_sync_ff[2];
         if (lsa_sync_ff[1] == lsa_sync_ff[2]) lsa_q <= lsa_sync_ff[2];
         if (lsb_sync_ff[1] == lsb_sync_ff[2]) lsb_q <= lsb_sync_ff[2];
      end
   end

   // [RULE11] Undervoltage qualification timer
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         uv_cnt_ff <= '0;
         uv_ok_ff <= 1'b0;
      end
      else if (!uv_ok_q)
      begin
         uv_cnt_ff <= '0;
         uv_ok_ff <= 1'b0;
      end
      else if (uv_cnt_ff == UW'(UVLO_QUAL_CYC))
         uv_ok_ff <= 1'b1;
      else
         uv_cnt_ff <= uv_cnt_ff + 1'b1;
   end

   // [RULE22] Thermal fault latch, held until cooled
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         thermal_ff <= 1'b0;
      else if (ot_q)
         thermal_ff <= 1'b1;
      else if (cool_q)
         thermal_ff <= 1'b0;
   end

   // [RULE24] Device reset from enable, supply and thermal
   assign soft_rst = !en_q || !uv_ok_ff || thermal_ff;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         run_ff <= 1'b0;
         run_d_ff <= 1'b0;
      end
      else
      begin
         run_ff <= !soft_rst;
         run_d_ff <= run_ff;
      end
   end

   // [RULE23] [RULE13] Latch mode selections while in reset only
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ac_mode_ff <= 1'b0;
         cad_ff <= 1'b1;
         hcap_ff <= 1'b1;
         c5a_ff <= 1'b0;
         c5b_ff <= 1'b0;
      end
      else if (!run_ff)
      begin
         ac_mode_ff <= dm_q;
         cad_ff <= i_cadence_mode;
         hcap_ff <= i_high_cap;
         c5a_ff <= !lsa_q;
         c5b_ff <= !lsb_q;
      end
   end

   // [RULE3] [RULE9] Base limit: startup fixed, else class
   always_comb
   begin
      lim_base = i_class_limit_ma;
      if (state_ff == ST_STARTUP)
         lim_base = STARTUP_LIMIT_MA;
      else if (i_class == 3'h5 && c5a_ff && c5b_ff)
         lim_base = C5C_LIM_MA;
      else if (i_class == 3'h5 && c5b_ff)
         lim_base = C5B_LIM_MA;
      else if (i_class == 3'h5 && c5a_ff)
         lim_base = C5A_LIM_MA;
   end

   // [RULE10] Foldback: linear from floor at 10 V to base at 27 V
   assign fold_prod = 22'(lim_base - i_foldback_current_floor) * 22'(i_port_dv - FOLD_LO_DV);
   always_comb
   begin
      if (i_port_dv >= FOLD_HI_DV || lim_base <= i_foldback_current_floor)
         lim_fold = lim_base;
      else if (i_port_dv <= FOLD_LO_DV)
         lim_fold = i_foldback_current_floor;
      else
         lim_fold = i_foldback_current_floor + 12'(fold_prod / 22'(FOLD_HI_DV - FOLD_LO_DV));
   end

   // [RULE4] Cut threshold near 88 percent of active limit
   assign cut_prod = lim_fold * CUT_RATIO_Q8;
   always_comb
   begin
      cut = cut_prod[19:8];
      if (state_ff == ST_NORMAL && i_class == 3'h5 && c5a_ff && c5b_ff)
         cut = C5C_CUT_MA;
      else if (state_ff == ST_NORMAL && i_class == 3'h5 && c5b_ff)
         cut = C5B_CUT_MA;
      else if (state_ff == ST_NORMAL && i_class == 3'h5 && c5a_ff)
         cut = C5A_CUT_MA;
      if (i_port_dv < FOLD_HI_DV && cut > cut_prod[19:8])
         cut = cut_prod[19:8];
   end

   assign over_lim = i_sensed_load_current > lim_fold;
   assign over_cut = i_sensed_load_current > cut;
   // [RULE5] Up condition depends on phase
   assign over_now = (state_ff == ST_STARTUP) ? over_lim : (state_ff == ST_NORMAL) && over_cut;
   assign fault_full = fault_ff >= FW'(FAULT_SCALE);
   assign disc_low = ac_mode_ff ? (i_probe_peak < i_ac_disconnect_threshold)
                                : (i_sensed_load_current < i_dc_disconnect_threshold);

   // [RULE25] [RULE6] Saturating up/down fault counter
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         fault_ff <= '0;
      else if (!run_ff)
         fault_ff <= '0;
      // [RULE1] Cleared on powered entry
      else if (state_ff == ST_OFF && i_load_valid && !ov_q)
         fault_ff <= '0;
      else if (over_now)
         fault_ff <= (fault_ff + FW'(FAULT_UP_STEP) >= FW'(FAULT_SCALE)) ?
                     FW'(FAULT_SCALE) : fault_ff + FW'(FAULT_UP_STEP);
      else if (fault_ff >= FW'(FAULT_DOWN_STEP))
         fault_ff <= fault_ff - FW'(FAULT_DOWN_STEP);
      else
         fault_ff <= '0;
   end

   // Startup and disconnect timers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         start_cnt_ff <= '0;
         disc_cnt_ff <= '0;
      end
      // [RULE1] Disconnect timer cleared on powered entry
      else if (state_ff != ST_STARTUP && state_ff != ST_NORMAL)
      begin
         start_cnt_ff <= '0;
         disc_cnt_ff <= '0;
      end
      else
      begin
         if (start_cnt_ff != SW'(STARTUP_CYC))
            start_cnt_ff <= start_cnt_ff + 1'b1;
         // [RULE14] [RULE16] Low-current persistence
         if (state_ff != ST_NORMAL || !disc_low)
            disc_cnt_ff <= '0;
         else if (disc_cnt_ff != DW'(DISC_CYC))
            disc_cnt_ff <= disc_cnt_ff + 1'b1;
      end
   end

   // Power state machine
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_ff <= ST_OFF;
         oc_fault_ff <= 1'b0;
      end
      // [RULE11] [RULE22] [RULE24] Reset holds port off
      else if (!run_ff)
      begin
         state_ff <= ST_OFF;
         oc_fault_ff <= 1'b0;
      end
      else
         case (state_ff)
            ST_OFF:
               if (i_load_valid && !ov_q)
               begin
                  state_ff <= ST_STARTUP;
                  oc_fault_ff <= 1'b0;
               end
            // [RULE2] Startup to normal on timer
            ST_STARTUP:
               if (ov_q)
                  state_ff <= ST_OFF;
               else if (fault_full)
               begin
                  state_ff <= ST_COOLDOWN;
                  oc_fault_ff <= 1'b1;
               end
               else if (start_cnt_ff == SW'(STARTUP_CYC))
                  state_ff <= ST_NORMAL;
            ST_NORMAL:
               // [RULE12] Overvoltage kills power
               if (ov_q)
                  state_ff <= ST_OFF;
               // [RULE7] Full scale removes power
               else if (fault_full)
               begin
                  state_ff <= ST_COOLDOWN;
                  oc_fault_ff <= 1'b1;
               end
               else if (disc_cnt_ff == DW'(DISC_CYC))
                  state_ff <= ST_OFF;
            // [RULE8] Wait for counter to drain
            ST_COOLDOWN:
               if (fault_ff == '0)
                  state_ff <= ST_OFF;
            default:
               state_ff <= ST_OFF;
         endcase
   end

   // [RULE17] [RULE18] [RULE19] LED mode selection
   assign led_bus.mode = (state_ff == ST_NORMAL || state_ff == ST_STARTUP) ? LED_SOLID :
                         oc_fault_ff ? LED_CODE2 : (i_sig_bad ? LED_CODE5 : LED_DARK);
   assign led_bus.dim_en = dim_q;

   ppsup_led_gen #(
      .FLASH_CYC (LED_FLASH_CYC),
      .GAP_CYC (LED_GAP_CYC)
   ) u_led (
      .i_clk (i_clk),
      .i_rst_n (i_rst_n),
      .led (led_bus.gen)
   );

   // Registered outputs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_port_on <= 1'b0;
         o_current_limit_threshold <= 12'h000;
         o_overcurrent <= 1'b0;
         o_in_reset <= 1'b1;
         o_cadence_mode <= 1'b0;
         o_high_cap <= 1'b0;
         o_led_out <= 1'b0;
         o_led_oe <= 1'b0;
      end
      else
      begin
         o_port_on <= run_ff && (state_ff == ST_STARTUP || state_ff == ST_NORMAL) && !ov_q;
         o_current_limit_threshold <= lim_fold;
         // [RULE4] Overcurrent flag in normal state
         o_overcurrent <= (state_ff == ST_NORMAL) && over_cut;
         o_in_reset <= !run_d_ff;
         o_cadence_mode <= cad_ff;
         o_high_cap <= hcap_ff;
         o_led_out <= 1'b0;
         o_led_oe <= led_bus.led_on;
      end
   end
endmodule // ppsup_top

/* File: tb/ppsup_pd_model.sv */
// Powered device model: draws a set current while the port is powered.
// Assumes the bench picks the draw; board strap for disconnect mode is fixed.
`timescale 1ns/1ps
module ppsup_pd_model #(
   parameter bit AC_CAP = 1'b0
)(
   // Clock and port state
   input wire logic i_clk,
   input wire logic i_port_on,
   input wire logic [11:0] i_draw_ma,
   // Sensed values and strap
   output logic [11:0] o_sensed_load_current,
   output logic [11:0] o_probe_peak,
   output logic o_disconnect_mode_pin
);
   assign o_disconnect_mode_pin = AC_CAP;
   // No current flows into an unpowered load
   always_ff @(posedge i_clk)
   begin
      o_sensed_load_current <= i_port_on ? i_draw_ma : 12'h000;
      o_probe_peak <= i_port_on ? i_draw_ma : 12'h000;
   end
endmodule // ppsup_pd_model

/* File: tb/ppsup_props.sv */
// Checker for the supervisor top ports.
// Assumes the bind below; one clock domain.
`timescale 1ns/1ps
module ppsup_props
   import ppsup_pkg::*;
#(
   parameter int FAULT_SCALE = 6000000
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Watched ports
   input wire logic i_enable,
   input wire logic i_load_valid,
   input wire logic i_supply_overvoltage_detect,
   input wire logic i_over_temp,
   input wire logic o_port_on,
   input wire logic [11:0] o_current_limit_threshold,
   input wire logic o_overcurrent,
   input wire logic o_in_reset,
   input wire logic o_cadence_mode,
   input wire logic o_high_cap,
   input wire logic o_led_out
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [15:0] oc_run_ff;
   // Length of the current overcurrent run while powered
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         oc_run_ff <= 16'h0000;
      else
         oc_run_ff <= (o_overcurrent && o_port_on) ? oc_run_ff + 16'h0001 : 16'h0000;
   end
   AST_RST_OFF: assert property (o_in_reset |-> !o_port_on)
      else $error("port powered in reset");
   AST_PWR_ANSWER: assert property ($rose(o_port_on) |-> $past(i_load_valid, 2))
      else $error("port powered without load request");
   AST_START_LIM: assert property ($rose(o_port_on) |-> ##[0:3]
      (o_current_limit_threshold <= STARTUP_LIMIT_MA))
      else $error("startup limit too high");
   AST_FAULT_TIME: assert property (oc_run_ff <= FAULT_SCALE / 8 + 4)
      else $error("overcurrent outlasted fault period");
   AST_OV_OFF: assert property (i_supply_overvoltage_detect |-> ##[0:6] !o_port_on)
      else $error("port kept on at overvoltage");
   AST_HOT_OFF: assert property (i_over_temp |-> ##[0:8] !o_port_on)
      else $error("port kept on when hot");
   AST_EN_RST: assert property (!i_enable [*2] |-> ##[0:6] o_in_reset)
      else $error("enable low did not reset");
   AST_STRAP_HOLD: assert property (!o_in_reset && !$past(o_in_reset) |->
      $stable(o_cadence_mode) && $stable(o_high_cap))
      else $error("strap changed outside reset");
   AST_LED_SINK: assert property (o_led_out == 1'b0)
      else $error("led pin driven high");
endmodule // ppsup_props
bind ppsup_top ppsup_props #(.FAULT_SCALE(FAULT_SCALE)) ppsup_props_inst (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_enable(i_enable), .i_load_valid(i_load_valid),
   .i_supply_overvoltage_detect(i_supply_overvoltage_detect), .i_over_temp(i_over_temp),
   .o_port_on(o_port_on), .o_current_limit_threshold(o_current_limit_threshold),
   .o_overcurrent(o_overcurrent), .o_in_reset(o_in_reset), .o_cadence_mode(o_cadence_mode),
   .o_high_cap(o_high_cap), .o_led_out(o_led_out));

/* File: tb/ppsup_top_tb.sv */
// Bench for the supervisor: power-up, faults, class 5, lockouts, LED.
// Assumes small timing parameters; DC disconnect strap.
`timescale 1ns/1ps
module ppsup_top_tb;
   import ppsup_pkg::*;
   logic i_clk, i_rst_n, i_enable, sel_a_n, sel_b_n, cad, dim, ov, hot, cool, lv, sig, uv_n;
   logic port_on, oc, in_rst, cad_q, hc_q, led_out, led_oe, mode_pin;
   logic [2:0] cls;
   logic [11:0] draw, cur, peak, lim, clim, floor_ma;
   logic [9:0] pdv;
   int err_count, checked, n;
   logic [11:0] c5_lim [3] = '{C5A_LIM_MA, C5B_LIM_MA, C5C_LIM_MA};
   logic [1:0] c5_sel [3] = '{2'b01, 2'b10, 2'b00};
   // Design under test
   ppsup_top #(.STARTUP_CYC(100), .FAULT_SCALE(80), .DISC_CYC(50), .UVLO_QUAL_CYC(20),
      .LED_FLASH_CYC(10), .LED_GAP_CYC(40)) ppsup_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_enable(i_enable), .i_limit_select_a_n(sel_a_n), .i_limit_select_b_n(sel_b_n),
      .i_disconnect_mode_pin(mode_pin), .i_cadence_mode(cad), .i_high_cap(cad),
      .i_led_dimming_enable(dim), .i_supply_undervoltage_lockout_n(uv_n),
      .i_supply_overvoltage_detect(ov), .i_over_temp(hot), .i_under_temp_130(cool),
      .i_load_valid(lv), .i_sig_bad(sig), .i_class(cls), .i_class_limit_ma(clim),
      .i_sensed_load_current(cur), .i_dc_disconnect_threshold(12'h00A), .i_probe_peak(peak),
      .i_ac_disconnect_threshold(12'h00A), .i_foldback_current_floor(floor_ma),
      .i_port_dv(pdv), .i_supply_dv(10'h1E0), .o_port_on(port_on),
      .o_current_limit_threshold(lim), .o_overcurrent(oc), .o_in_reset(in_rst),
      .o_cadence_mode(cad_q), .o_high_cap(hc_q), .o_led_out(led_out), .o_led_oe(led_oe));
   // Far-side load
   ppsup_pd_model #(.AC_CAP(1'b0)) ppsup_pd_model_inst (.i_clk(i_clk), .i_port_on(port_on),
      .i_draw_ma(draw), .o_sensed_load_current(cur), .o_probe_peak(peak),
      .o_disconnect_mode_pin(mode_pin));
   // Clock
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Helpers
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic wait_on(input logic exp, input int k);
      n = 0;
      while (port_on !== exp && n < k)
      begin
         tick(1);
         n++;
      end
      chk({11'h000, port_on}, {11'h000, exp});
   endtask
   task automatic restart(input logic a_n, input logic b_n);
      lv = 1'b0;
      sel_a_n = a_n;
      sel_b_n = b_n;
      i_enable = 1'b0;
      tick(10);
      i_enable = 1'b1;
      n = 0;
      while (in_rst !== 1'b0 && n < 200)
      begin
         tick(1);
         n++;
      end
      chk({11'h000, in_rst}, 12'h000);
   endtask
   task automatic power_up();
      lv = 1'b0;
      tick(2);
      lv = 1'b1;
      wait_on(1'b1, 5);
   endtask
   task automatic finish_test();
      $display("counts: checked %0d, err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #500000;
      err_count++;
      finish_test();
   end
   // Test sequence
   initial
   begin
      {i_rst_n, i_enable, sel_a_n, sel_b_n, cad, dim, ov, hot, lv, sig} = 10'b0111100000;
      cool = 1'b1;
      uv_n = 1'b1;
      cls = 3'h2;
      clim = 12'h258;
      draw = 12'h064;
      floor_ma = 12'h0C8;
      pdv = 10'h1F4;
      err_count = 0;
      checked = 0;
      tick(12);
      i_rst_n = 1'b1;
      restart(1'b1, 1'b1);
      cad = 1'b0;
      power_up();
      chk(lim, STARTUP_LIMIT_MA);
      tick(105);
      chk(lim, 12'h258);
      chk({11'h000, led_oe}, 12'h001);
      chk({10'h000, cad_q, hc_q}, 12'h003);
      dim = 1'b1;
      tick(10);
      n = 0;
      repeat (4000)
      begin
         tick(1);
         n += led_oe;
      end
      chk(n[11:0], 12'h0FA);
      dim = 1'b0;
      $display("test power and dimming done");
      draw = 12'h230;
      tick(3);
      chk({11'h000, oc}, 12'h001);
      wait_on(1'b0, 30);
      chk({11'h000, n >= 7 && n <= 14}, 12'h001);
      lv = 1'b0;
      draw = 12'h064;
      n = 0;
      repeat (55)
      begin
         tick(1);
         n += led_oe;
      end
      chk(n[11:0], 12'h013);
      lv = 1'b1;
      tick(5);
      chk({11'h000, port_on}, 12'h000);
      wait_on(1'b1, 40);
      $display("test overcurrent done");
      tick(105);
      pdv = 10'h050;
      tick(5);
      chk(lim, floor_ma);
      pdv = 10'h1F4;
      lv = 1'b0;
      draw = 12'h000;
      tick(40);
      chk({11'h000, port_on}, 12'h001);
      wait_on(1'b0, 25);
      tick(2);
      chk({11'h000, led_oe}, 12'h000);
      draw = 12'h064;
      $display("test foldback and disconnect done");
      cls = 3'h5;
      for (int i = 0; i < 3; i++)
      begin
         restart(c5_sel[i][1], c5_sel[i][0]);
         power_up();
         tick(105);
         chk(lim, c5_lim[i]);
      end
      $display("test class 5 done");
      ov = 1'b1;
      wait_on(1'b0, 5);
      ov = 1'b0;
      power_up();
      hot = 1'b1;
      cool = 1'b0;
      wait_on(1'b0, 10);
      tick(5);
      chk({11'h000, in_rst}, 12'h001);
      hot = 1'b0;
      cool = 1'b1;
      restart(1'b1, 1'b1);
      power_up();
      uv_n = 1'b0;
      wait_on(1'b0, 10);
      uv_n = 1'b1;
      tick(15);
      chk({11'h000, in_rst}, 12'h001);
      restart(1'b1, 1'b1);
      sig = 1'b1;
      tick(2);
      n = 0;
      repeat (140)
      begin
         tick(1);
         n += led_oe;
      end
      chk(n[11:0], 12'h032);
      sig = 1'b0;
      $display("test lockouts done");
      finish_test();
   end
endmodule // ppsup_top_tb
